// ### design/cam_host.sv
// host controller driving the cam over its strobe and data pins
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1: device stores 256 words of 48 bits
// R2: device compares comparand against all words
// R3: priority encoder yields matching location index
// R4: lowest matching location wins on multiples
// R5: one 16-bit bus, host drives writes
// R6: writes only under low write strobe
// R7: device drives bus only under output enable
// R8: chip select low frames every strobe
// R9: 48-bit word moves as three pieces
// R10: device drives match low on any hit
module cam_host #(
  parameter int STROBE = cam_pkg::STROBE_CYC
) (
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  input  wire logic                        clkEn,
  input  wire logic                        reqValid,
  input  wire cam_pkg::cam_req_s           req,
  output logic                             reqReady,
  output logic                             rspValid,
  output logic [cam_pkg::DATA_W-1:0]       rspData,
  output logic                             hit,
  output cam_pkg::cam_pins_s               pins,
  input  wire logic [cam_pkg::DATA_W-1:0]  dIn,
  input  wire logic                        anyHitN
);
  // sequencer steps; on a write, SETUP and the end of the last GAP each move several pins at once
  typedef enum {
    IDLE,       // waiting for a request
    SETUP,      // select and present write data
    STROBE_ON,  // strobe held low
    GAP         // recovery before the next piece
  } cam_state_e;

  // ==========================================================
  // derived step counts
  // last strobe count; two extra cycles cover the read synchroniser
  localparam logic [7:0] STROBE_END = 8'(STROBE + 2);
  // last gap count; data stays driven through the gap for hold time
  localparam logic [7:0] GAP_END    = 8'(STROBE - 1);

  // ==========================================================
  // pin input synchronisers
  // bus and match pin are asynchronous to mclk; only the second
  // stage of each pair is read by the logic below
  logic [cam_pkg::DATA_W-1:0] dS1_reg, dS1_next;
  logic [cam_pkg::DATA_W-1:0] dS2_reg, dS2_next;
  logic                       hS1_reg, hS1_next;
  logic                       hS2_reg, hS2_next;

  // shift both pin inputs one stage per enabled edge
  always_comb begin
    dS1_next = dIn;
    dS2_next = dS1_reg;
    hS1_next = anyHitN;
    hS2_next = hS1_reg;
  end

  // register the stages; match pin idles high, meaning no hit
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dS1_reg <= 16'h0000;
      dS2_reg <= 16'h0000;
      hS1_reg <= 1'b1;
      hS2_reg <= 1'b1;
    end else if (clkEn) begin
      dS1_reg <= dS1_next;
      dS2_reg <= dS2_next;
      hS1_reg <= hS1_next;
      hS2_reg <= hS2_next;
    end
  end

  // ==========================================================
  // transfer sequencer
  cam_state_e                  state_reg, state_next;
  logic [1:0]                  piece_reg, piece_next;
  logic [7:0]                  cnt_reg, cnt_next;
  cam_pkg::cam_req_s           cur_reg, cur_next;
  cam_pkg::cam_pins_s          pins_reg, pins_next;
  logic                        ready_reg, ready_next;
  logic                        rv_reg, rv_next;
  logic [cam_pkg::DATA_W-1:0]  rd_reg, rd_next;
  logic                        hit_reg, hit_next;

  // next-state for the pin sequence
  // every value holds unless a step below moves it
  always_comb begin
    state_next = state_reg;
    piece_next = piece_reg;
    cnt_next   = cnt_reg;
    cur_next   = cur_reg;
    pins_next  = pins_reg;
    ready_next = ready_reg;
    case (state_reg)
      // a request is only taken while idle and ready
      IDLE: begin
        if (reqValid && ready_reg) begin
          cur_next       = req;
          piece_next     = 2'h0;
          ready_next     = 1'b0;
          state_next     = SETUP;
        end
      end
      SETUP: begin
        pins_next.csN = 1'b0;                         // R8
        if (cur_reg.isWrite) begin
          // lowest piece first, bus driven by host
          pins_next.dOut    = cur_reg.word[cam_pkg::DATA_W*piece_reg +: cam_pkg::DATA_W]; // R9
          pins_next.dOutEnN = 1'b0;                   // R5
        end else begin
          pins_next.dOutEnN = 1'b1;                   // R7
        end
        cnt_next   = 8'h00;
        state_next = STROBE_ON;
      end
      STROBE_ON: begin
        if (cur_reg.isWrite) pins_next.weN = 1'b0;    // R6
        else pins_next.oeN = 1'b0;                    // R7
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == STROBE_END) begin
          // both strobes rise together; read data is captured apart
          pins_next.weN = 1'b1;
          pins_next.oeN = 1'b1;
          cnt_next      = 8'h00;
          state_next    = GAP;
        end
      end
      GAP: begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == GAP_END) begin
          // release the bus only after the device has latched it
          pins_next.dOutEnN = 1'b1;
          if (cur_reg.isWrite && piece_reg != cam_pkg::PIECE_LAST) begin
            piece_next = piece_reg + 2'h1;            // R9
            state_next = SETUP;
          end else begin
            pins_next.csN = 1'b1;                     // R8
            ready_next    = 1'b1;
            state_next    = IDLE;
          end
        end
      end
      default: state_next = IDLE;
    endcase
  end

  // register the sequencer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= IDLE;
      piece_reg <= 2'h0;
      cnt_reg   <= 8'h00;
      cur_reg   <= '0;
      // all strobes high and bus released while in reset
      pins_reg  <= '{
        csN:     1'b1,
        weN:     1'b1,
        oeN:     1'b1,
        dOut:    16'h0000,
        dOutEnN: 1'b1
      };
      ready_reg <= 1'b1;
    end else if (clkEn) begin
      state_reg <= state_next;
      piece_reg <= piece_next;
      cnt_reg   <= cnt_next;
      cur_reg   <= cur_next;
      pins_reg  <= pins_next;
      ready_reg <= ready_next;
    end
  end

  // ==========================================================
  // read capture
  // data is taken on the last strobe count, once the bus has
  // stood still through both synchroniser stages
  always_comb begin
    rv_next = 1'b0;
    rd_next = rd_reg;
    if (state_reg == STROBE_ON && cnt_reg == STROBE_END && !cur_reg.isWrite) begin
      rd_next = dS2_reg;                              // R7
      rv_next = 1'b1;
    end
  end

  // register the response; data holds until the next read
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rv_reg <= 1'b0;
      rd_reg <= 16'h0000;
    end else if (clkEn) begin
      rv_reg <= rv_next;
      rd_reg <= rd_next;
    end
  end

  // ==========================================================
  // match indication
  // the pin is active low, the output active high; it lags the
  // pin by two synchroniser stages and this register
  always_comb begin
    hit_next = ~hS2_reg;
  end

  // register the match flag
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hit_reg <= 1'b0;
    end else if (clkEn) begin
      hit_reg <= hit_next;
    end
  end

  // ==========================================================
  // outputs, each straight from a flip-flop
  assign reqReady = ready_reg;
  assign rspValid = rv_reg;
  assign rspData  = rd_reg;
  assign hit      = hit_reg;
  assign pins     = pins_reg;
endmodule
`default_nettype wire

// ### include/cam_pkg.sv
// shared constants and types for the cam host controller
package cam_pkg;
  localparam int DATA_W    = 16;
  localparam int WORD_W    = 48;
  localparam int PIECES    = 3;
  localparam int DEPTH     = 256;
  localparam int ADDR_W    = 8;
  // strobe low time and gap in mclk cycles (25 ns period)
  localparam int STROBE_NS = 50;
  localparam int CLK_NS    = 25;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] PIECE_LAST = 2'h2;
  // host request
  typedef struct packed {
    logic              isWrite;   // 1 write word, 0 read result
    logic [WORD_W-1:0] word;
  } cam_req_s;
  // pin bundle to the device
  typedef struct packed {
    logic              csN;
    logic              weN;
    logic              oeN;
    logic [DATA_W-1:0] dOut;
    logic              dOutEnN;
  } cam_pins_s;
endpackage

// ### verification/cam_host_assertions.sv
// pin protocol checks for the cam host controller
`timescale 1ns/10ps
`default_nettype none
module cam_host_assertions (
  input wire logic               mclk,
  input wire logic               rstn,
  input wire cam_pkg::cam_pins_s pins,
  input wire logic               rspValid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_busFree; !pins.oeN |-> pins.dOutEnN; endproperty
  a_busFree: assert property (p_busFree) else $error("bus fight");
  property p_wrData; !pins.weN |-> !pins.dOutEnN && $stable(pins.dOut); endproperty
  a_wrData: assert property (p_wrData) else $error("write data moved");
  property p_select; !(pins.weN && pins.oeN) |-> !pins.csN; endproperty
  a_select: assert property (p_select) else $error("strobe unselected");
  property p_oneDir; pins.weN || pins.oeN; endproperty
  a_oneDir: assert property (p_oneDir) else $error("both strobes low");
  // strobe low for STROBE+2 samples at the default STROBE of 2
  property p_readLen; $fell(pins.oeN) |-> !pins.oeN [*4] ##1 (pins.oeN && rspValid); endproperty
  a_readLen: assert property (p_readLen) else $error("read strobe length");
  c_write: cover property ($fell(pins.weN));
  c_read: cover property (rspValid);
  c_frame: cover property (!pins.csN ##1 pins.csN);
endmodule
bind cam_host cam_host_assertions chk (.mclk(mclk), .rstn(rstn), .pins(pins), .rspValid(rspValid));
`default_nettype wire

// ### verification/cam_dev_model.sv
// behavioural model of the match memory on the host pins
`timescale 1ns/10ps
`default_nettype none
module cam_dev_model (
  input  wire logic               mclk,
  input  wire logic               storeMode,
  input  wire cam_pkg::cam_pins_s pins,
  output logic [15:0]             bus,
  output logic                    anyHitN
);
  logic [47:0] mem [256];
  logic [47:0] cmp = '1, asm;
  logic [15:0] last = '0;
  logic        wePrev = 1;
  int          n = 0, pc = 0, hitIdx = -1;
  // released bus shows the inverse of its last level
  assign bus = !pins.dOutEnN ? pins.dOut : (!pins.csN && !pins.oeN) ? hitIdx[15:0] : ~last;
  assign anyHitN = hitIdx < 0;
  // piece assembly on write strobe rise, then parallel compare
  always @(posedge mclk) begin
    last <= bus;
    if (pins.csN) pc = 0;
    else if (pins.weN && !wePrev) begin
      asm = {pins.dOut, asm[47:16]};
      pc++;
      if (pc == 3 && storeMode) mem[n] = asm;
      if (pc == 3 && storeMode) n++;
      else if (pc == 3) cmp = asm;
    end
    wePrev = pins.weN;
    hitIdx = -1;
    for (int i = n - 1; i >= 0; i--) if (mem[i] === cmp) hitIdx = i;
  end
endmodule
`default_nettype wire

// ### verification/tb.sv
// self-checking bench for the cam host controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk = 0, rstn = 0, reqValid = 0, storeMode = 1, reqReady, rspValid, hit, anyHitN;
  logic clkEn = 1;
  cam_pkg::cam_req_s  req = '0;
  cam_pkg::cam_pins_s pins;
  logic [15:0]        rspData, bus;
  int                 failures = 0, checks = 0;
  cam_host uut (.mclk(mclk), .rstn(rstn), .clkEn(clkEn), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .hit(hit), .pins(pins),
    .dIn(bus), .anyHitN(anyHitN));
  cam_dev_model dev (.mclk(mclk), .storeMode(storeMode), .pins(pins), .bus(bus), .anyHitN(anyHitN));
  initial forever #12.5 mclk = ~mclk;
  task chk(string name, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask
  // one request, waits for idle first and for completion after
  task xfer(logic wr, logic [47:0] w);
    int k;
    for (k = 0; k < 60 && !reqReady; k++) @(posedge mclk) #2;
    req = '{wr, w};
    reqValid = 1;
    @(posedge mclk) #2 reqValid = 0;
    for (k = 0; k < 60 && !(wr ? reqReady : rspValid); k++) @(posedge mclk) #2;
    if (k == 60) failures++;
  endtask
  task t_fill;
    storeMode = 1;
    xfer(1, 48'hA5A5_1234_0F0F);
    xfer(1, 48'h0000_FFFF_8001);
    xfer(1, 48'hA5A5_1234_0F0F);
    $display("fill done");
  endtask
  // enable low: a pending request waits and no pin moves
  task t_freeze;
    clkEn = 0;
    req = '{1'b1, 48'h1111_2222_3333};
    reqValid = 1;
    repeat (5) @(posedge mclk);
    #2 chk("frozen ready", 16'h0001, {15'h0, reqReady});
    chk("frozen select", 16'h0001, {15'h0, pins.csN});
    reqValid = 0;
    clkEn = 1;
    $display("freeze done");
  endtask
  task t_look(logic [47:0] w, logic [15:0] idx, logic h);
    storeMode = 0;
    xfer(1, w);
    repeat (4) @(posedge mclk);
    #2 chk("hit", {15'h0, h}, {15'h0, hit});
    xfer(0, 48'h0);
    chk("index", idx, rspData);
    $display("lookup done");
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    #2 rstn = 1;
    t_fill;
    t_freeze;
    t_look(48'hA5A5_1234_0F0F, 16'h0000, 1);
    t_look(48'h0000_FFFF_8001, 16'h0001, 1);
    t_look(48'h0000_FFFF_8002, 16'hFFFF, 0);
    print_verdict;
  end
  // watchdog
  initial begin
    #(25 * 4000);
    failures++;
    print_verdict;
  end
endmodule
`default_nettype wire
